//--- hw/acr_config_regs.sv
// Digital back-end configuration register bank with APB slave and control outputs
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - All writable registers reset to zero; status reads ready
// - Select bit plus gate enables offset correction
// - Fourteen-bit user word split high/low
// - High count is two to ten-plus-exponent
// - Bit zero auto-enables burst mode
// - Low count two to thirteen-plus-exponents
// - Feature gate enables gain and correction
// - Band select: zero 90, one 45 MHz
// - Pair bits enable burst per pair
// - Burst flag replaces data LSB
// - Boost disable only under pin override
// - Override picks register or pin boost
// - Source select: fast or normal overrange
// - Global power down, slow wake
// - Shutdown pin role: standby or power-down
// - All slow bits allow slow clock
// - Separate skew codes per channel pair
// - Skew code maps through fixed table
// - Eleven-bit pattern uses word bits 13..3

module acr_config_regs
	import acr_pkg::*;
#(
	parameter int DEEP_WAKE_CYCLES    = ACR_DEEP_WAKE_CYC,
	parameter int STANDBY_WAKE_CYCLES = ACR_STANDBY_WAKE_CYC
) (
	input  wire logic               sys_clk_in,
	input  wire logic               sys_rst_in,
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire logic [11:0]        paddr_in,
	input  wire logic [31:0]        pwdata_in,
	input  wire logic [3:0]         pstrb_in,
	output logic      [31:0]        prdata_out,
	output logic                    pready_out,
	output logic                    pslverr_out,
	input  wire logic               boost_pin_in,
	input  wire logic               shutdown_pin_in,
	input  wire acr_sample_t        sample_in [4],
	output logic      [13:0]        sample_data_out [4],
	output logic      [3:0]         overrange_flag_out,
	output logic                    offset_fix_active_out,
	output logic      [10:0]        offset_mid_code_out,
	output logic                    gain_enable_out,
	output logic      [13:0]        user_word_out,
	output logic      [10:0]        user_word_short_out,
	output logic                    burst_auto_enable_out,
	output logic      [25:0]        high_sample_count_out,
	output logic      [31:0]        low_sample_count_out,
	output logic                    wide_capture_pair_ab_out,
	output logic                    wide_capture_pair_cd_out,
	output logic                    boost_active_out,
	output logic                    boost_band_45_out,
	output logic                    converter_ready_out,
	output logic                    standby_out,
	output logic                    power_down_out,
	output logic                    slow_clock_mode_out,
	output logic      [3:0]         pair_ab_clkout_skew_out,
	output logic      [3:0]         pair_cd_clkout_skew_out,
	output logic signed [10:0]      pair_ab_skew_ps_out,
	output logic signed [10:0]      pair_cd_skew_ps_out
);

	// ************************************************************
	// Register storage
	// ************************************************************
	logic [7:0] offset_fix_control_reg;
	logic [7:0] user_word_high_reg;
	logic [7:0] user_word_low_reg;
	logic [7:0] burst_high_count_config_reg;
	logic [7:0] digital_feature_config_reg;
	logic [7:0] burst_pair_control_reg;
	logic [7:0] overrange_power_control_reg;
	logic [7:0] slow_clock_bit_a_reg;
	logic [7:0] slow_clock_bit_b_reg;
	logic [7:0] slow_clock_bit_d_reg;
	logic [7:0] slow_clock_bit_c_reg;
	logic [7:0] pair_ab_clock_skew_reg;
	logic [7:0] pair_cd_clock_skew_reg;

	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;

	logic [7:0]  reg_index;
	logic        addr_ok;
	logic        mapped;
	logic        bus_error;
	logic        setup_phase;
	logic        write_fire;
	logic [7:0]  wr_byte;
	logic [7:0]  rd_byte;

	// ************************************************************
	// APB address decode
	// ************************************************************
	assign reg_index   = paddr_in[9:2];
	assign addr_ok     = (paddr_in[11:10] == 2'h0) && (paddr_in[1:0] == 2'h0);
	assign setup_phase = psel_in && !penable_in;
	assign wr_byte     = pwdata_in[7:0];

	always_comb begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		case (reg_index)
			ACR_IDX_STATUS:     rd_byte = {4'h0, slow_clock_mode_out, power_down_out, standby_out,
				converter_ready_out};
			ACR_IDX_OFFSET_FIX: rd_byte = offset_fix_control_reg;
			ACR_IDX_WORD_HIGH:  rd_byte = user_word_high_reg;
			ACR_IDX_WORD_LOW:   rd_byte = user_word_low_reg;
			ACR_IDX_BURST_HIGH: rd_byte = burst_high_count_config_reg;
			ACR_IDX_DIGITAL:    rd_byte = digital_feature_config_reg;
			ACR_IDX_BURST_PAIR: rd_byte = burst_pair_control_reg;
			ACR_IDX_OVR_POWER:  rd_byte = overrange_power_control_reg;
			ACR_IDX_SLOW_A:     rd_byte = slow_clock_bit_a_reg;
			ACR_IDX_SLOW_B:     rd_byte = slow_clock_bit_b_reg;
			ACR_IDX_SLOW_D:     rd_byte = slow_clock_bit_d_reg;
			ACR_IDX_SLOW_C:     rd_byte = slow_clock_bit_c_reg;
			ACR_IDX_SKEW_AB:    rd_byte = pair_ab_clock_skew_reg;
			ACR_IDX_SKEW_CD:    rd_byte = pair_cd_clock_skew_reg;
			default:            mapped  = 1'b0;
		endcase
	end

	// Status is read-only, so a write to it is answered with an error
	assign bus_error  = !addr_ok || !mapped || (pwrite_in && (reg_index == ACR_IDX_STATUS));
	assign write_fire = psel_in && penable_in && pready_reg && pwrite_in && !bus_error && pstrb_in[0];

	// ************************************************************
	// APB answer: one wait-free access phase after each setup
	// ************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= setup_phase;
			pslverr_reg <= setup_phase && bus_error;
			prdata_reg  <= (setup_phase && !pwrite_in && !bus_error) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// ************************************************************
	// Register writes
	// ************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			offset_fix_control_reg      <= ACR_RESET_VALUE;
			user_word_high_reg          <= ACR_RESET_VALUE;
			user_word_low_reg           <= ACR_RESET_VALUE;
			burst_high_count_config_reg <= ACR_RESET_VALUE;
			digital_feature_config_reg  <= ACR_RESET_VALUE;
			burst_pair_control_reg      <= ACR_RESET_VALUE;
			overrange_power_control_reg <= ACR_RESET_VALUE;
			slow_clock_bit_a_reg        <= ACR_RESET_VALUE;
			slow_clock_bit_b_reg        <= ACR_RESET_VALUE;
			slow_clock_bit_d_reg        <= ACR_RESET_VALUE;
			slow_clock_bit_c_reg        <= ACR_RESET_VALUE;
			pair_ab_clock_skew_reg      <= ACR_RESET_VALUE;
			pair_cd_clock_skew_reg      <= ACR_RESET_VALUE;
		end else if (write_fire) begin
			// Masking keeps reserved bits at zero even if the host disobeys
			case (reg_index)
				ACR_IDX_OFFSET_FIX: offset_fix_control_reg      <= wr_byte & ACR_MASK_OFFSET_FIX;
				ACR_IDX_WORD_HIGH:  user_word_high_reg          <= wr_byte & ACR_MASK_WORD_HIGH;
				ACR_IDX_WORD_LOW:   user_word_low_reg           <= wr_byte & ACR_MASK_WORD_LOW;
				ACR_IDX_BURST_HIGH: burst_high_count_config_reg <= wr_byte & ACR_MASK_BURST_HIGH;
				ACR_IDX_DIGITAL:    digital_feature_config_reg  <= wr_byte & ACR_MASK_DIGITAL;
				ACR_IDX_BURST_PAIR: burst_pair_control_reg      <= wr_byte & ACR_MASK_BURST_PAIR;
				ACR_IDX_OVR_POWER:  overrange_power_control_reg <= wr_byte & ACR_MASK_OVR_POWER;
				ACR_IDX_SLOW_A:     slow_clock_bit_a_reg        <= wr_byte & ACR_MASK_SLOW;
				ACR_IDX_SLOW_B:     slow_clock_bit_b_reg        <= wr_byte & ACR_MASK_SLOW;
				ACR_IDX_SLOW_D:     slow_clock_bit_d_reg        <= wr_byte & ACR_MASK_SLOW;
				ACR_IDX_SLOW_C:     slow_clock_bit_c_reg        <= wr_byte & ACR_MASK_SLOW;
				ACR_IDX_SKEW_AB:    pair_ab_clock_skew_reg      <= wr_byte & ACR_MASK_SKEW_AB;
				ACR_IDX_SKEW_CD:    pair_cd_clock_skew_reg      <= wr_byte & ACR_MASK_SKEW_CD;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Field extraction
	// ************************************************************
	logic       offset_fix_select;
	logic       feature_gate;
	logic [3:0] high_count_exponent;
	logic [1:0] low_count_exponent;
	logic       wide_capture_range_flag_on;
	logic       boost_disable;
	logic       boost_pin_override;
	logic       overrange_source_select;
	logic       global_power_down;
	logic       shutdown_pin_role;
	logic [3:0] slow_clock_bits;
	logic [3:0] pair_ab_clkout_skew;
	logic [3:0] pair_cd_clkout_skew;
	logic [1:0] pair_burst;

	assign offset_fix_select          = offset_fix_control_reg[ACR_POS_OFFSET_FIX_SEL];
	assign feature_gate               = digital_feature_config_reg[ACR_POS_FEATURE_GATE];
	assign high_count_exponent        = burst_high_count_config_reg[ACR_POS_HIGH_EXP_LSB +: 4];
	assign low_count_exponent         = digital_feature_config_reg[ACR_POS_LOW_EXP_LSB +: 2];
	assign wide_capture_range_flag_on = burst_pair_control_reg[ACR_POS_RANGE_FLAG_ON];
	assign boost_disable              = burst_pair_control_reg[ACR_POS_BOOST_DISABLE];
	assign overrange_source_select    = overrange_power_control_reg[ACR_POS_OVR_SOURCE];
	assign global_power_down          = overrange_power_control_reg[ACR_POS_GLOBAL_PD];
	assign shutdown_pin_role          = overrange_power_control_reg[ACR_POS_PIN_ROLE];
	assign slow_clock_bits            = {slow_clock_bit_d_reg[0], slow_clock_bit_c_reg[0],
		slow_clock_bit_b_reg[0], slow_clock_bit_a_reg[0]};
	assign pair_ab_clkout_skew        = pair_ab_clock_skew_reg[ACR_POS_SKEW_AB_LSB +: 4];
	assign pair_cd_clkout_skew        = pair_cd_clock_skew_reg[ACR_POS_SKEW_CD_LSB +: 4];
	assign pair_burst                 = {burst_pair_control_reg[ACR_POS_PAIR_CD],
		burst_pair_control_reg[ACR_POS_PAIR_AB]};
	// The override bit's own register lies outside this bank, so it is kept in the digital register here
	assign boost_pin_override         = digital_feature_config_reg[ACR_POS_BOOST_OVERRIDE];

	// ************************************************************
	// Feature controls
	// ************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			offset_fix_active_out <= 1'b0;
			offset_mid_code_out   <= 11'h000;
			gain_enable_out       <= 1'b0;
			boost_band_45_out     <= 1'b0;
			boost_active_out      <= 1'b0;
		end else begin
			offset_fix_active_out <= offset_fix_select && feature_gate;
			offset_mid_code_out   <= (offset_fix_select && feature_gate) ? ACR_MID_CODE : 11'h000;
			gain_enable_out       <= feature_gate;
			boost_band_45_out     <= digital_feature_config_reg[ACR_POS_BOOST_BAND];
			// Register disable matters only once the pin is overridden
			boost_active_out      <= boost_pin_override ? !boost_disable : boost_pin_in;
		end
	end

	// ************************************************************
	// Test word, burst counts and slow clock mode
	// ************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			user_word_out            <= 14'h0000;
			user_word_short_out      <= 11'h000;
			burst_auto_enable_out    <= 1'b0;
			high_sample_count_out    <= 26'h000_0000;
			low_sample_count_out     <= 32'h0000_0000;
			wide_capture_pair_ab_out <= 1'b0;
			wide_capture_pair_cd_out <= 1'b0;
			slow_clock_mode_out      <= 1'b0;
		end else begin
			user_word_out         <= {user_word_high_reg[5:0], user_word_low_reg};
			user_word_short_out   <= {user_word_high_reg[5:0], user_word_low_reg[7:3]};
			burst_auto_enable_out <= burst_high_count_config_reg[ACR_POS_AUTO_BURST];
			high_sample_count_out <= 26'h000_0001 << (ACR_HIGH_EXP_BASE + {1'b0, high_count_exponent});
			low_sample_count_out  <= 32'h0000_0001 << (ACR_LOW_EXP_BASE + {1'b0, high_count_exponent}
				+ {3'h0, low_count_exponent});
			wide_capture_pair_ab_out <= pair_burst[0];
			wide_capture_pair_cd_out <= pair_burst[1];
			slow_clock_mode_out      <= &slow_clock_bits;
		end
	end

	// ************************************************************
	// Output clock skew
	// ************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pair_ab_clkout_skew_out <= 4'h0;
			pair_cd_clkout_skew_out <= 4'h0;
			pair_ab_skew_ps_out     <= 11'sd0;
			pair_cd_skew_ps_out     <= 11'sd0;
		end else begin
			pair_ab_clkout_skew_out <= pair_ab_clkout_skew;
			pair_cd_clkout_skew_out <= pair_cd_clkout_skew;
			pair_ab_skew_ps_out     <= acr_skew_ps(pair_ab_clkout_skew);
			pair_cd_skew_ps_out     <= acr_skew_ps(pair_cd_clkout_skew);
		end
	end

	// ************************************************************
	// Per-channel data and overrange flag insertion
	// ************************************************************
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_chan
			logic flag;
			logic insert;
			assign flag   = overrange_source_select ? sample_in[ch].ovr_normal : sample_in[ch].ovr_fast;
			// Channels 0,1 form pair AB and 2,3 pair CD
			assign insert = pair_burst[ch / 2] && wide_capture_range_flag_on;
			always_ff @(posedge sys_clk_in) begin
				if (sys_rst_in) begin
					sample_data_out[ch]    <= 14'h0000;
					overrange_flag_out[ch] <= 1'b0;
				end else begin
					overrange_flag_out[ch] <= flag;
					sample_data_out[ch]    <= insert ? {sample_in[ch].data[13:1], flag}
						: sample_in[ch].data;
				end
			end
		end
	endgenerate

	// ************************************************************
	// Power state and wake timing
	// ************************************************************
	acr_pwr_state_t pwr_state_reg;
	acr_pwr_state_t pwr_state_next;
	logic [31:0]    wake_count_reg;
	logic [31:0]    wake_count_next;
	logic           deep_request;
	logic           standby_request;

	assign deep_request    = global_power_down || (shutdown_pin_in && shutdown_pin_role);
	assign standby_request = shutdown_pin_in && !shutdown_pin_role;

	always_comb begin
		pwr_state_next  = pwr_state_reg;
		wake_count_next = wake_count_reg;
		case (pwr_state_reg)
			ACR_PWR_RUN: begin
				if (deep_request) begin
					pwr_state_next = ACR_PWR_DOWN;
				end else if (standby_request) begin
					pwr_state_next = ACR_PWR_STANDBY;
				end
			end
			ACR_PWR_STANDBY: begin
				if (deep_request) begin
					pwr_state_next = ACR_PWR_DOWN;
				end else if (!standby_request) begin
					pwr_state_next  = ACR_PWR_WAKE;
					wake_count_next = 32'(STANDBY_WAKE_CYCLES - 1);
				end
			end
			ACR_PWR_DOWN: begin
				if (!deep_request) begin
					pwr_state_next  = ACR_PWR_WAKE;
					wake_count_next = 32'(DEEP_WAKE_CYCLES - 1);
				end
			end
			ACR_PWR_WAKE: begin
				if (deep_request) begin
					pwr_state_next = ACR_PWR_DOWN;
				end else if (standby_request) begin
					pwr_state_next = ACR_PWR_STANDBY;
				end else if (wake_count_reg == 32'h0000_0000) begin
					pwr_state_next = ACR_PWR_RUN;
				end else begin
					wake_count_next = wake_count_reg - 32'h0000_0001;
				end
			end
			default: pwr_state_next = ACR_PWR_RUN;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pwr_state_reg       <= ACR_PWR_RUN;
			wake_count_reg      <= 32'h0000_0000;
			converter_ready_out <= 1'b1;
			standby_out         <= 1'b0;
			power_down_out      <= 1'b0;
		end else begin
			pwr_state_reg       <= pwr_state_next;
			wake_count_reg      <= wake_count_next;
			converter_ready_out <= (pwr_state_next == ACR_PWR_RUN);
			standby_out         <= (pwr_state_next == ACR_PWR_STANDBY);
			power_down_out      <= (pwr_state_next == ACR_PWR_DOWN);
		end
	end

	assign prdata_out  = prdata_reg;
	assign pready_out  = pready_reg;
	assign pslverr_out = pslverr_reg;

endmodule // acr_config_regs
`default_nettype wire

//--- inc/acr_pkg.sv
// Package for the converter digital configuration register bank
package acr_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0] ACR_IDX_STATUS     = 8'h00;
	localparam logic [7:0] ACR_IDX_OFFSET_FIX = 8'h3D;
	localparam logic [7:0] ACR_IDX_WORD_HIGH  = 8'h3F;
	localparam logic [7:0] ACR_IDX_WORD_LOW   = 8'h40;
	localparam logic [7:0] ACR_IDX_BURST_HIGH = 8'h41;
	localparam logic [7:0] ACR_IDX_DIGITAL    = 8'h42;
	localparam logic [7:0] ACR_IDX_BURST_PAIR = 8'h44;
	localparam logic [7:0] ACR_IDX_OVR_POWER  = 8'h45;
	localparam logic [7:0] ACR_IDX_SLOW_A     = 8'h4A;
	localparam logic [7:0] ACR_IDX_SLOW_B     = 8'h62;
	localparam logic [7:0] ACR_IDX_SLOW_D     = 8'h7A;
	localparam logic [7:0] ACR_IDX_SLOW_C     = 8'h92;
	localparam logic [7:0] ACR_IDX_SKEW_AB    = 8'hA9;
	localparam logic [7:0] ACR_IDX_SKEW_CD    = 8'hAC;

	// ************************************************************
	// Writable bit masks; reserved bits store nothing and read zero
	// ************************************************************
	localparam logic [7:0] ACR_MASK_OFFSET_FIX = 8'h20;
	localparam logic [7:0] ACR_MASK_WORD_HIGH  = 8'h3F;
	localparam logic [7:0] ACR_MASK_WORD_LOW   = 8'hFF;
	localparam logic [7:0] ACR_MASK_BURST_HIGH = 8'h1F;
	localparam logic [7:0] ACR_MASK_DIGITAL    = 8'h8F;
	localparam logic [7:0] ACR_MASK_BURST_PAIR = 8'hC5;
	localparam logic [7:0] ACR_MASK_OVR_POWER  = 8'h0D;
	localparam logic [7:0] ACR_MASK_SLOW       = 8'h01;
	localparam logic [7:0] ACR_MASK_SKEW_AB    = 8'h0F;
	localparam logic [7:0] ACR_MASK_SKEW_CD    = 8'h78;
	localparam logic [7:0] ACR_RESET_VALUE     = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int ACR_POS_OFFSET_FIX_SEL = 5;
	localparam int ACR_POS_HIGH_EXP_LSB   = 1;
	localparam int ACR_POS_AUTO_BURST     = 0;
	localparam int ACR_POS_FEATURE_GATE   = 3;
	localparam int ACR_POS_BOOST_BAND     = 2;
	localparam int ACR_POS_LOW_EXP_LSB    = 0;
	localparam int ACR_POS_PAIR_CD        = 7;
	localparam int ACR_POS_PAIR_AB        = 6;
	localparam int ACR_POS_RANGE_FLAG_ON  = 2;
	localparam int ACR_POS_BOOST_DISABLE  = 0;
	localparam int ACR_POS_BOOST_OVERRIDE = 7;
	localparam int ACR_POS_OVR_SOURCE     = 3;
	localparam int ACR_POS_GLOBAL_PD      = 2;
	localparam int ACR_POS_PIN_ROLE       = 0;
	localparam int ACR_POS_SKEW_AB_LSB    = 0;
	localparam int ACR_POS_SKEW_CD_LSB    = 3;

	// ************************************************************
	// Counts and timing
	// ************************************************************
	localparam logic [4:0]  ACR_HIGH_EXP_BASE    = 5'h0A;
	localparam logic [4:0]  ACR_LOW_EXP_BASE     = 5'h0D;
	localparam logic [10:0] ACR_MID_CODE         = 11'h3FF;
	localparam int          ACR_CLK_MHZ          = 200;
	localparam int          ACR_DEEP_WAKE_US     = 100;
	localparam int          ACR_STANDBY_WAKE_US  = 10;
	localparam int          ACR_DEEP_WAKE_CYC    = ACR_DEEP_WAKE_US * ACR_CLK_MHZ;
	localparam int          ACR_STANDBY_WAKE_CYC = ACR_STANDBY_WAKE_US * ACR_CLK_MHZ;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		ACR_PWR_RUN     = 4'h1,
		ACR_PWR_STANDBY = 4'h2,
		ACR_PWR_DOWN    = 4'h4,
		ACR_PWR_WAKE    = 4'h8
	} acr_pwr_state_t;

	typedef struct packed {
		logic [13:0] data;
		logic        ovr_fast;
		logic        ovr_normal;
	} acr_sample_t;

	// Output clock skew in ps for each four-bit delay code
	function automatic logic signed [10:0] acr_skew_ps(input logic [3:0] code);
		case (code)
			4'h0: acr_skew_ps = 11'sd0;
			4'h1: acr_skew_ps = -11'sd30;
			4'h2: acr_skew_ps = 11'sd70;
			4'h3: acr_skew_ps = 11'sd30;
			4'h4: acr_skew_ps = -11'sd150;
			4'h5: acr_skew_ps = -11'sd180;
			4'h6: acr_skew_ps = -11'sd70;
			4'h7: acr_skew_ps = -11'sd110;
			4'h8: acr_skew_ps = 11'sd270;
			4'h9: acr_skew_ps = 11'sd230;
			4'hA: acr_skew_ps = 11'sd340;
			4'hB: acr_skew_ps = 11'sd300;
			4'hC: acr_skew_ps = 11'sd140;
			4'hD: acr_skew_ps = 11'sd110;
			4'hE: acr_skew_ps = 11'sd200;
			default: acr_skew_ps = 11'sd170;
		endcase
	endfunction

endpackage

//--- tb/acr_chk.sv
// Assertion checker for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module acr_chk (
	input wire logic               sys_clk_in,
	input wire logic               sys_rst_in,
	input wire logic               psel_in,
	input wire logic               penable_in,
	input wire logic               pready_out,
	input wire logic               pslverr_out,
	input wire logic               offset_fix_active_out,
	input wire logic [10:0]        offset_mid_code_out,
	input wire logic               gain_enable_out,
	input wire logic [13:0]        user_word_out,
	input wire logic [10:0]        user_word_short_out,
	input wire logic [25:0]        high_sample_count_out,
	input wire logic               standby_out,
	input wire logic               power_down_out,
	input wire logic               converter_ready_out,
	input wire logic [3:0]         pair_ab_clkout_skew_out,
	input wire logic signed [10:0] pair_ab_skew_ps_out
);
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence setup_s;
		psel_in && !penable_in;
	endsequence
	chk_ready_one_cycle: assert property (setup_s |=> pready_out ##1 !pready_out)
		else $error("ready not a single cycle after setup");
	chk_err_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("error flag without ready");
	chk_mid_code_value: assert property (offset_fix_active_out |-> ##[0:1] offset_mid_code_out == 11'h3FF)
		else $error("mid code not 1023 while correcting");
	chk_fix_needs_gate: assert property (offset_fix_active_out |-> ##[0:1] gain_enable_out)
		else $error("correction active with gate off");
	chk_short_word: assert property (user_word_short_out == user_word_out[13:3])
		else $error("short word not upper eleven bits");
	chk_high_count_shape: assert property ($onehot0(high_sample_count_out) && high_sample_count_out[9:0] == 10'h000)
		else $error("high count not a power of two from 1024");
	chk_power_exclusive: assert property ($onehot0({standby_out, power_down_out, converter_ready_out}))
		else $error("power states overlap");
	chk_skew_code_four: assert property (pair_ab_clkout_skew_out == 4'h4 |-> ##[0:1] pair_ab_skew_ps_out == -11'sd150)
		else $error("skew code four not minus 150 ps");
endmodule // acr_chk
bind acr_config_regs acr_chk u_chk (.*);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import acr_pkg::*;
	// ************************************************************
	// Signals and model
	// ************************************************************
	logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic boost_pin_in = 1'b0, shutdown_pin_in = 1'b0, pready_out, pslverr_out;
	logic [11:0] paddr_in = '0;
	logic [31:0] pwdata_in = '0, prdata_out, low_sample_count_out, r, err_count = '0, n_compared = '0, seed;
	logic [3:0] pstrb_in = 4'hF, overrange_flag_out, pair_ab_clkout_skew_out, pair_cd_clkout_skew_out;
	acr_sample_t sample_in [4];
	logic [13:0] sample_data_out [4], user_word_out;
	logic [10:0] offset_mid_code_out, user_word_short_out;
	logic signed [10:0] pair_ab_skew_ps_out, pair_cd_skew_ps_out;
	logic [25:0] high_sample_count_out;
	logic offset_fix_active_out, gain_enable_out, burst_auto_enable_out, wide_capture_pair_ab_out, e;
	logic wide_capture_pair_cd_out, boost_active_out, boost_band_45_out, converter_ready_out;
	logic standby_out, power_down_out, slow_clock_mode_out;
	logic [7:0] d, m [13];
	localparam logic [7:0] IX [13] = '{ACR_IDX_OFFSET_FIX, ACR_IDX_WORD_HIGH, ACR_IDX_WORD_LOW, ACR_IDX_BURST_HIGH,
		ACR_IDX_DIGITAL, ACR_IDX_BURST_PAIR, ACR_IDX_OVR_POWER, ACR_IDX_SLOW_A, ACR_IDX_SLOW_B, ACR_IDX_SLOW_D,
		ACR_IDX_SLOW_C, ACR_IDX_SKEW_AB, ACR_IDX_SKEW_CD};
	localparam logic [7:0] MK [13] = '{ACR_MASK_OFFSET_FIX, ACR_MASK_WORD_HIGH, ACR_MASK_WORD_LOW,
		ACR_MASK_BURST_HIGH, ACR_MASK_DIGITAL, ACR_MASK_BURST_PAIR, ACR_MASK_OVR_POWER, ACR_MASK_SLOW,
		ACR_MASK_SLOW, ACR_MASK_SLOW, ACR_MASK_SLOW, ACR_MASK_SKEW_AB, ACR_MASK_SKEW_CD};
	localparam int PS [16] = '{0, -30, 70, 30, -150, -180, -70, -110, 270, 230, 340, 300, 140, 110, 200, 170};
	// Short wake counts keep the power scenario brief
	acr_config_regs #(.DEEP_WAKE_CYCLES(20), .STANDBY_WAKE_CYCLES(5)) dut (.*);
	always #2.5 sys_clk_in = ~sys_clk_in;
	task automatic chk(input logic [31:0] s, input logic [31:0] x, input string nm);
		n_compared++;
		if (s !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Holds the request until ready is sampled high, then releases
	task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
		int n;
		psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= {2'h0, ix, 2'h0}; pwdata_in <= {24'h0, wd};
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin @(posedge sys_clk_in); n++; end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) begin chk(0, 1, "ready"); report_and_stop(); end
		r = prdata_out; e = pslverr_out; psel_in <= 1'b0; penable_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		seed = 32'hD208;
		foreach (sample_in[i]) sample_in[i] = '0;
		repeat (4) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		foreach (IX[i]) begin apb(0, IX[i], 8'h00); chk(r, 0, "reset value"); end
		repeat (8) begin
			foreach (IX[i]) begin
				d = $random(seed); m[i] = d & MK[i]; boost_pin_in <= d[0];
				apb(1, IX[i], m[i]); apb(0, IX[i], 8'h00); chk(r, {24'h0, m[i]}, "readback");
			end
			repeat (2) @(posedge sys_clk_in);
			chk(user_word_out, {m[1][5:0], m[2]}, "user word");
			chk(user_word_short_out, {m[1][5:0], m[2][7:3]}, "short word");
			chk(high_sample_count_out, 32'h1 << (10 + m[3][4:1]), "high count");
			chk(low_sample_count_out, 32'h1 << (13 + m[3][4:1] + m[4][1:0]), "low count");
			chk(burst_auto_enable_out, m[3][0], "auto burst");
			chk({offset_mid_code_out, offset_fix_active_out}, (m[0][5] & m[4][3]) ? {ACR_MID_CODE, 1'b1} : 12'h000,
				"offset fix");
			chk({gain_enable_out, boost_band_45_out}, m[4][3:2], "gate and band");
			chk({wide_capture_pair_cd_out, wide_capture_pair_ab_out}, m[5][7:6], "pairs");
			chk(boost_active_out, m[4][7] ? !m[5][0] : boost_pin_in, "boost");
			chk(slow_clock_mode_out, m[7][0] & m[8][0] & m[9][0] & m[10][0], "slow clock");
			chk({pair_ab_clkout_skew_out, pair_cd_clkout_skew_out}, {m[11][3:0], m[12][6:3]}, "skew codes");
			chk(32'(pair_cd_skew_ps_out), PS[m[12][6:3]], "skew ps");
			chk(32'(pair_ab_skew_ps_out), PS[m[11][3:0]], "skew ps ab");
		end
		apb(0, 8'h3E, 8'h00); chk(r, 0, "unmapped data"); chk(e, 1, "unmapped error");
		apb(1, 8'hCF, 8'h08); chk(e, 1, "trim outside bank");
		apb(1, IX[11], 8'h04); apb(1, IX[5], 8'h44); apb(1, IX[6], 8'h08);
		sample_in[0] <= '{14'h3FFF, 1'b1, 1'b0}; sample_in[2] <= '{14'h3FFF, 1'b1, 1'b0};
		repeat (3) @(posedge sys_clk_in);
		chk({sample_data_out[0], sample_data_out[2]}, {14'h3FFE, 14'h3FFF}, "flag insert");
		chk(overrange_flag_out[0], 0, "flag source");
		apb(1, IX[6], 8'h04); repeat (2) @(posedge sys_clk_in);
		chk({power_down_out, converter_ready_out}, 2'h2, "power down");
		apb(1, IX[6], 8'h00); repeat (25) @(posedge sys_clk_in);
		chk(converter_ready_out, 1, "wake");
		shutdown_pin_in <= 1'b1; repeat (2) @(posedge sys_clk_in);
		chk({standby_out, converter_ready_out}, 2'h2, "standby");
		shutdown_pin_in <= 1'b0; repeat (8) @(posedge sys_clk_in);
		chk(converter_ready_out, 1, "standby wake");
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
